// ---- core/sad_pkg.sv ----
// shared constants, types and maps of the system address decoder
package sad_pkg;

  // address widths: 36-bit memory space, 16-bit i/o space
  localparam int ADDR_W = 36;
  localparam int IO_W   = 16;
  localparam int NWIN   = 10;
  localparam int NIOWIN = 2;
  localparam int NSEG   = 12;

  // fixed legacy boundaries
  localparam logic [ADDR_W-1:0] LOW640_TOP = 36'h0_000a_0000;
  localparam logic [ADDR_W-1:0] VGA_BASE   = 36'h0_000a_0000;
  localparam logic [ADDR_W-1:0] VGA_TOP    = 36'h0_000c_0000;
  localparam logic [ADDR_W-1:0] MONO_BASE  = 36'h0_000b_0000;
  localparam logic [ADDR_W-1:0] MONO_TOP   = 36'h0_000b_8000;
  localparam logic [ADDR_W-1:0] SEG_BASE   = 36'h0_000c_0000;
  localparam logic [ADDR_W-1:0] SEG_TOP    = 36'h0_000f_0000;
  localparam logic [ADDR_W-1:0] ONE_MB     = 36'h0_0010_0000;
  localparam int                SEG_SHIFT  = 14;
  localparam int                MB_SHIFT   = 20;
  localparam logic [6:0]        STOLEN_MAX = 7'h40;

  // monochrome adapter i/o ports
  localparam logic [IO_W-1:0] MONO_PORTS [6] = '{16'h03b4, 16'h03b5, 16'h03b8,
                                                 16'h03b9, 16'h03ba, 16'h03bf};

  // memory window index and size (log2 bytes)
  localparam int W_EGRESS = 0;
  localparam int W_HUBREG = 1;
  localparam int W_DLINK  = 2;
  localparam int W_FLAT   = 3;
  localparam int W_MMIO0  = 4;
  localparam int W_MMIO1  = 5;
  localparam int W_APERT  = 6;
  localparam int W_GTT    = 7;
  localparam int W_MBOX0  = 8;
  localparam int W_MBOX1  = 9;
  localparam logic [5:0] WIN_LOG2 [NWIN] = '{6'h0c, 6'h0e, 6'h0c, 6'h1a, 6'h13,
                                             6'h13, 6'h1c, 6'h12, 6'h04, 6'h04};
  localparam logic [5:0] FLAT_LOG2_MIN = 6'h1a;
  localparam logic [1:0] FLAT_SEL_MAX  = 2'h2;

  // i/o windows: graphics index/data pair, keyboard-and-text
  localparam int         IW_GFX   = 0;
  localparam int         IW_KT    = 1;
  localparam logic [5:0] IOWIN_LOG2 [NIOWIN] = '{6'h03, 6'h03};
  localparam int         GFX_DATA_BIT = 2;

  // routing targets, one-hot
  typedef enum logic [6:0] {
    TGT_DRAM    = 7'h01,
    TGT_GFX     = 7'h02,
    TGT_PCIE    = 7'h04,
    TGT_HUBLINK = 7'h08,
    TGT_HUBREG  = 7'h10,
    TGT_MGMT    = 7'h20,
    TGT_ABORT   = 7'h40
  } sad_target_type;

  localparam sad_target_type WIN_TGT [NWIN] = '{TGT_HUBREG, TGT_HUBREG, TGT_HUBREG,
    TGT_HUBREG, TGT_GFX, TGT_GFX, TGT_GFX, TGT_GFX, TGT_MGMT, TGT_MGMT};

  // request source
  typedef enum logic [1:0] {
    SRC_CPU     = 2'h0,
    SRC_PCIE    = 2'h1,
    SRC_HUBLINK = 2'h2
  } sad_src_type;

  // output stage states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_FULL = 2'h2
  } sad_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              io;
    sad_src_type       src;
    logic              mgmt_mode;
    logic              snoop;
  } sad_req_type;

  typedef struct packed {
    logic [ADDR_W-1:0]            top_of_low_dram;
    logic [6:0]                   stolen_mb;
    logic [NWIN-1:0][ADDR_W-1:0]  win_base;
    logic [NWIN-1:0]              win_en;
    logic [1:0]                   flat_size;
    logic [NIOWIN-1:0][IO_W-1:0]  io_base;
    logic [NIOWIN-1:0]            io_en;
    logic                         gfx_vga_en;
    logic                         vga_en;
    logic                         mono_adapter_present;
    logic                         smram_en;
    logic [2*NSEG-1:0]            seg_attr;
  } sad_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              io;
    sad_src_type       src;
    sad_target_type    target;
    logic              gfx_io_data;
    logic              cfg_access;
  } sad_res_type;

endpackage : sad_pkg

// ---- core/sad_win_match.sv ----
// base-aligned window hit test with a run-time size
`timescale 1ns/1ps
module sad_win_match #(
  parameter int AW = 36
) (
  // window
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] base,
  input  wire logic [5:0]    size_log2,
  input  wire logic          en,
  // result
  output logic               hit
);

  // bits above the window size must equal the base
  assign hit = en && (((addr ^ base) >> size_log2) == '0);

endmodule : sad_win_match

// ---- core/sad_seg_attr.sv ----
// attribute lookup for the twelve 16 KB segments from 768 KB to 960 KB
`timescale 1ns/1ps
module sad_seg_attr (
  // access
  input  wire logic [sad_pkg::ADDR_W-1:0]   addr,
  input  wire logic                         write,
  input  wire logic                         force_dram,
  // attributes, {write enable, read enable} per segment
  input  wire logic [2*sad_pkg::NSEG-1:0]   attr,
  // result
  output logic                              hit,
  output logic                              to_dram
);

  logic [sad_pkg::ADDR_W-1:0] off;
  logic [4:0]                 idx;
  logic [1:0]                 pair;

  // segment index, held at zero off-range to keep the select in bounds
  assign hit  = (addr >= sad_pkg::SEG_BASE) && (addr < sad_pkg::SEG_TOP);
  assign off  = addr - sad_pkg::SEG_BASE;
  assign idx  = hit ? 5'(off >> sad_pkg::SEG_SHIFT) : 5'h00;
  assign pair = attr[idx*2 +: 2];

  // clear attribute sends that direction to the hub link
  assign to_dram = force_dram || (write ? pair[1] : pair[0]);

endmodule : sad_seg_attr

// ---- core/sad_decoder.sv ----
// system address decoder: routes memory and i/o cycles to their target
// Summary of operation
// - memory addresses are 36 bits wide, 64 GB of space.
// - space from 768 KB to 960 KB has per-segment disabled, rw, write-only, read-only attributes.
// - nothing above top of low dram is ever remapped into dram.
// - dram decode wins over any overlapping window; among overlapping windows the lowest index wins.
// - below top of low dram only hub-link writes to pcie video may peer; enforced only in a0000h-bffffh, other peers may reach hub link or graphics.
// - egress and downstream-link register windows decode 4 KB each.
// - flat config window is 64, 128 or 256 MB, 4 KB per function.
// - stolen-memory control reserves 0 to 64 MB of dram for graphics.
// - graphics has 512 KB register windows, 256 MB aperture, 256 KB table.
// - graphics i/o window is an index/data pair reaching graphics registers.
// - mailbox windows decode 16 bytes, keyboard-text i/o window 8 bytes.
// - the lowest 640 KB always goes to dram.
// - legacy video goes to graphics, pcie or hub link; mono range with adapter-present first, then graphics.
// - after graphics, vga enable picks pcie, else hub link.
// - enabled smram: cpu in management mode reaches dram, else video routing.
// - peer cycles to enabled smram use video routing or master-abort.
// - mono adapter range b0000h-b7fffh follows steering and adapter-present.
// - mono adapter i/o ports follow the same steering.
// - expansion area is eight 16 KB segments with four states each.
// - bios extension is four 16 KB segments; disabled ones not remapped.
// - non-snooped peer accesses to attribute segments always go to dram.
// - accesses to disabled segments default to the hub link.
`timescale 1ns/1ps
module sad_decoder (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // configuration, held stable by software
  input  wire sad_pkg::sad_cfg_type cfg,
  // request
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire sad_pkg::sad_req_type req,
  // routed result
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output sad_pkg::sad_res_type      res_q
);

  sad_pkg::sad_state_type        state_q;
  sad_pkg::sad_state_type        state_d;
  sad_pkg::sad_target_type       tgt;
  sad_pkg::sad_target_type       video_tgt;
  logic                          take;
  logic                          is_cpu;
  logic                          in_vga;
  logic                          in_mono;
  logic                          mono_port;
  logic                          seg_hit;
  logic                          seg_dram;
  logic                          flat_hit;
  logic                          gfx_data;
  logic [sad_pkg::ADDR_W-1:0]    stolen_base;
  logic [5:0]                    flat_log2;
  logic [sad_pkg::NWIN-1:0]      win_hit;
  logic [sad_pkg::NIOWIN-1:0]    io_hit;
  logic [sad_pkg::IO_W-1:0]      io_addr;

  // legacy video steering shared by memory and i/o decode
  function automatic sad_pkg::sad_target_type video_route(
    input logic mono, input logic gfx_vga, input logic vga, input logic present);
    if (mono && present) begin
      return sad_pkg::TGT_HUBLINK;
    end else if (gfx_vga) begin
      return sad_pkg::TGT_GFX;
    end else if (vga) begin
      return sad_pkg::TGT_PCIE;
    end
    return sad_pkg::TGT_HUBLINK;
  endfunction : video_route

  // stolen size is clamped to its largest setting
  function automatic logic [sad_pkg::ADDR_W-1:0] stolen_bytes(input logic [6:0] mb);
    logic [6:0] m;
    m = (mb > sad_pkg::STOLEN_MAX) ? sad_pkg::STOLEN_MAX : mb;
    return sad_pkg::ADDR_W'(m) << sad_pkg::MB_SHIFT;
  endfunction : stolen_bytes

  // flat window size, the reserved selector is clamped to the largest
  function automatic logic [5:0] FLAT_LOG2(input logic [1:0] sel);
    logic [1:0] s;
    s = (sel > sad_pkg::FLAT_SEL_MAX) ? sad_pkg::FLAT_SEL_MAX : sel;
    return sad_pkg::FLAT_LOG2_MIN + 6'(s);
  endfunction : FLAT_LOG2

  // simple region flags
  assign io_addr     = req.addr[sad_pkg::IO_W-1:0];
  assign is_cpu      = (req.src == sad_pkg::SRC_CPU);
  assign in_vga      = (req.addr >= sad_pkg::VGA_BASE) && (req.addr < sad_pkg::VGA_TOP);
  assign in_mono     = (req.addr >= sad_pkg::MONO_BASE) && (req.addr < sad_pkg::MONO_TOP);
  assign stolen_base = cfg.top_of_low_dram - stolen_bytes(cfg.stolen_mb);
  assign flat_log2   = FLAT_LOG2(cfg.flat_size);
  assign video_tgt   = video_route(in_mono, cfg.gfx_vga_en, cfg.vga_en,
                                   cfg.mono_adapter_present);

  // memory windows; the flat config window takes its size from cfg
  for (genvar i = 0; i < sad_pkg::NWIN; i++) begin : g_win
    sad_win_match #(.AW(sad_pkg::ADDR_W)) u_win (
      .addr      (req.addr),
      .base      (cfg.win_base[i]),
      .size_log2 ((i == sad_pkg::W_FLAT) ? flat_log2 : sad_pkg::WIN_LOG2[i]),
      .en        (cfg.win_en[i]),
      .hit       (win_hit[i])
    );
  end

  // i/o windows: graphics index/data pair and keyboard-text
  for (genvar j = 0; j < sad_pkg::NIOWIN; j++) begin : g_iowin
    sad_win_match #(.AW(sad_pkg::IO_W)) u_iowin (
      .addr      (io_addr),
      .base      (cfg.io_base[j]),
      .size_log2 (sad_pkg::IOWIN_LOG2[j]),
      .en        (cfg.io_en[j]),
      .hit       (io_hit[j])
    );
  end

  // attribute segments; non-snooped peer traffic is forced to dram
  sad_seg_attr u_seg (
    .addr       (req.addr),
    .write      (req.write),
    .force_dram (!is_cpu && !req.snoop),
    .attr       (cfg.seg_attr),
    .hit        (seg_hit),
    .to_dram    (seg_dram)
  );

  // mono adapter port match
  always_comb begin
    mono_port = 1'b0;
    for (int k = 0; k < 6; k++) begin
      if (io_addr == sad_pkg::MONO_PORTS[k]) begin
        mono_port = 1'b1;
      end
    end
  end

  // routing decision
  always_comb begin
    tgt      = sad_pkg::TGT_HUBLINK;
    flat_hit = 1'b0;
    gfx_data = 1'b0;
    if (req.io) begin
      if (mono_port) begin
        tgt = video_route(1'b1, cfg.gfx_vga_en, cfg.vga_en,
                          cfg.mono_adapter_present);
      end else if (io_hit[sad_pkg::IW_GFX]) begin
        tgt      = sad_pkg::TGT_GFX;
        gfx_data = io_addr[sad_pkg::GFX_DATA_BIT];
      end else if (io_hit[sad_pkg::IW_KT]) begin
        tgt = sad_pkg::TGT_MGMT;
      end
    end else if (req.addr < sad_pkg::LOW640_TOP) begin
      tgt = sad_pkg::TGT_DRAM;
    end else if (in_vga) begin
      if (cfg.smram_en && is_cpu && req.mgmt_mode) begin
        tgt = sad_pkg::TGT_DRAM;
      end else if (is_cpu) begin
        tgt = video_tgt;
      end else if (video_tgt == sad_pkg::TGT_PCIE &&
                   req.src == sad_pkg::SRC_HUBLINK && req.write) begin
        tgt = sad_pkg::TGT_PCIE;
      end else begin
        tgt = sad_pkg::TGT_ABORT;
      end
    end else if (seg_hit) begin
      tgt = seg_dram ? sad_pkg::TGT_DRAM : sad_pkg::TGT_HUBLINK;
    end else if (req.addr < sad_pkg::ONE_MB) begin
      tgt = sad_pkg::TGT_HUBLINK;
    end else if (req.addr < stolen_base) begin
      tgt = sad_pkg::TGT_DRAM;
    end else if (req.addr < cfg.top_of_low_dram) begin
      tgt = sad_pkg::TGT_GFX;
    end else begin
      // above top of low dram only the windows claim; default hub link
      for (int w = sad_pkg::NWIN - 1; w >= 0; w--) begin
        if (win_hit[w]) begin
          tgt = sad_pkg::WIN_TGT[w];
        end
      end
      flat_hit = win_hit[sad_pkg::W_FLAT];
    end
  end

  // handshake of the single-entry output stage
  assign take      = req_valid && req_ready;
  assign req_ready = (state_q == sad_pkg::ST_IDLE) || out_ready;
  assign out_valid = (state_q == sad_pkg::ST_FULL);

  always_comb begin
    case (state_q)
      sad_pkg::ST_IDLE: begin
        state_d = take ? sad_pkg::ST_FULL : sad_pkg::ST_IDLE;
      end
      sad_pkg::ST_FULL: begin
        state_d = (out_ready && !take) ? sad_pkg::ST_IDLE : sad_pkg::ST_FULL;
      end
      default: begin
        state_d = sad_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= sad_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // result register, loaded on each accepted request
  always_ff @(posedge mclk) begin
    if (rst) begin
      res_q <= '{addr: '0, write: 1'b0, io: 1'b0, src: sad_pkg::SRC_CPU,
                 target: sad_pkg::TGT_HUBLINK, gfx_io_data: 1'b0, cfg_access: 1'b0};
    end else if (take) begin
      res_q.addr        <= req.addr;
      res_q.write       <= req.write;
      res_q.io          <= req.io;
      res_q.src         <= req.src;
      res_q.target      <= tgt;
      res_q.gfx_io_data <= gfx_data;
      res_q.cfg_access  <= flat_hit;
    end
  end

  // checks on the routing outcome
  a_low640_dram: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && req.addr < sad_pkg::LOW640_TOP
    |=> out_valid && res_q.target == sad_pkg::TGT_DRAM)
    else $error("low 640 KB not routed to dram");

  a_no_high_remap: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && req.addr >= cfg.top_of_low_dram && req.addr >= sad_pkg::ONE_MB
    |=> res_q.target != sad_pkg::TGT_DRAM)
    else $error("address above top of low dram sent to dram");

  a_dram_first: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && req.addr >= sad_pkg::ONE_MB && req.addr < stolen_base
    |=> res_q.target == sad_pkg::TGT_DRAM)
    else $error("window overrode dram decode");

  a_peer_video: assert property (@(posedge mclk) disable iff (rst)
    out_valid && !res_q.io && res_q.src != sad_pkg::SRC_CPU &&
    res_q.addr >= sad_pkg::VGA_BASE && res_q.addr < sad_pkg::VGA_TOP
    |-> res_q.target == sad_pkg::TGT_ABORT ||
        (res_q.target == sad_pkg::TGT_PCIE && res_q.write &&
         res_q.src == sad_pkg::SRC_HUBLINK))
    else $error("illegal peer cycle to video range");

  a_smram_cpu: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && in_vga && cfg.smram_en && is_cpu && req.mgmt_mode
    |=> res_q.target == sad_pkg::TGT_DRAM)
    else $error("management-mode access missed smram");

  a_gfx_video: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && in_vga && !in_mono && is_cpu && !req.mgmt_mode && cfg.gfx_vga_en
    |=> res_q.target == sad_pkg::TGT_GFX)
    else $error("video cycle not sent to graphics");

  a_mono_port: assert property (@(posedge mclk) disable iff (rst)
    take && req.io && mono_port && cfg.mono_adapter_present
    |=> res_q.target == sad_pkg::TGT_HUBLINK)
    else $error("mono adapter port misrouted");

  a_seg_nosnoop: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && seg_hit && !is_cpu && !req.snoop
    |=> res_q.target == sad_pkg::TGT_DRAM)
    else $error("non-snooped segment access not in dram");

  a_seg_disabled: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && seg_hit && is_cpu && !seg_dram
    |=> res_q.target == sad_pkg::TGT_HUBLINK)
    else $error("disabled segment not sent to hub link");

  a_out_hold: assert property (@(posedge mclk) disable iff (rst)
    out_valid && !out_ready |=> out_valid && $stable(res_q))
    else $error("result changed while stalled");

  a_mono_range: assert property (@(posedge mclk) disable iff (rst)
    take && !req.io && in_mono && is_cpu && !req.mgmt_mode && cfg.mono_adapter_present
    |=> res_q.target == sad_pkg::TGT_HUBLINK)
    else $error("mono adapter range misrouted");

  a_gfx_io_pair: assert property (@(posedge mclk) disable iff (rst)
    take && req.io && !mono_port && io_hit[sad_pkg::IW_GFX]
    |=> res_q.target == sad_pkg::TGT_GFX &&
        res_q.gfx_io_data == $past(io_addr[sad_pkg::GFX_DATA_BIT]))
    else $error("graphics i/o pair misrouted");

  // main scenarios
  c_dram_route: cover property (@(posedge mclk) disable iff (rst)
    out_valid && res_q.target == sad_pkg::TGT_DRAM);
  c_peer_abort: cover property (@(posedge mclk) disable iff (rst)
    out_valid && res_q.target == sad_pkg::TGT_ABORT);
  c_stall: cover property (@(posedge mclk) disable iff (rst)
    out_valid && !out_ready ##1 out_valid && out_ready);
  c_cfg_access: cover property (@(posedge mclk) disable iff (rst)
    out_valid && res_q.cfg_access);

endmodule : sad_decoder

// ---- dv/sad_consumer.sv ----
// result consumer model: takes routed results promptly or with stalls
`timescale 1ns/1ps
module sad_consumer (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // mode, high stalls on a shifting pattern
  input  wire logic slow,
  // result handshake
  input  wire logic out_valid,
  output logic      out_ready
);
  logic [4:0] pat_q;

  // ready moves only after a rising edge, never in mid-cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pat_q     <= 5'h1f;
      out_ready <= 1'b0;
    end else begin
      pat_q     <= {pat_q[3:0], pat_q[4] ^ pat_q[2]};
      out_ready <= !slow || pat_q[0] || !out_valid;
    end
  end
endmodule : sad_consumer

// ---- dv/test_sad_decoder.sv ----
// self-checking bench of the system address decoder
`timescale 1ns/1ps
module test_sad_decoder;
  typedef struct packed {
    sad_pkg::sad_target_type tgt;
    logic [35:0]             addr;
    logic                    gchk;
    logic                    gio;
    logic                    wr;
    logic                    io;
    sad_pkg::sad_src_type    src;
    logic                    cacc;
  } sad_exp_type;
  localparam sad_pkg::sad_target_type DR = sad_pkg::TGT_DRAM;
  localparam sad_pkg::sad_target_type GX = sad_pkg::TGT_GFX;
  localparam sad_pkg::sad_target_type PC = sad_pkg::TGT_PCIE;
  localparam sad_pkg::sad_target_type HL = sad_pkg::TGT_HUBLINK;
  localparam sad_pkg::sad_target_type HR = sad_pkg::TGT_HUBREG;
  localparam sad_pkg::sad_target_type MG = sad_pkg::TGT_MGMT;
  localparam sad_pkg::sad_target_type AB = sad_pkg::TGT_ABORT;
  localparam sad_pkg::sad_src_type    CPU = sad_pkg::SRC_CPU;
  localparam sad_pkg::sad_src_type    PCI = sad_pkg::SRC_PCIE;
  localparam sad_pkg::sad_src_type    HUB = sad_pkg::SRC_HUBLINK;
  // window edges and where each must land
  localparam logic [35:0] WA [13] = '{36'h0_f000_0fff, 36'h0_f000_1000, 36'h0_f002_0fff,
    36'h0_f002_1000, 36'h0_efff_ffff, 36'h0_d007_ffff, 36'hf_0007_ffff, 36'h0_cfff_ffff,
    36'h0_d013_ffff, 36'h0_d014_0000, 36'h0_d020_000f, 36'h0_d020_001f, 36'h0_d020_0020};
  localparam sad_pkg::sad_target_type WT [13] = '{HR, HL, HR, HL, HR, GX, GX, GX, GX, HL,
    MG, MG, HL};

  logic                 mclk, rst, req_valid, req_ready, out_valid, out_ready, slow;
  sad_pkg::sad_cfg_type cfg;
  sad_pkg::sad_req_type req;
  sad_pkg::sad_res_type res_q;
  sad_exp_type          exp_q[$];
  sad_exp_type          e;
  int                   err_count, compares, i, p;
  logic [31:0]          lfsr;
  logic [35:0]          a;

  sad_decoder dut_u (.mclk(mclk), .rst(rst), .cfg(cfg), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .out_valid(out_valid), .out_ready(out_ready),
    .res_q(res_q));
  sad_consumer far_u (.mclk(mclk), .rst(rst), .slow(slow), .out_valid(out_valid),
    .out_ready(out_ready));

  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rnd

  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] expv);
    compares++;
    if (seen !== expv) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // one request, held until taken; the expected result is queued at the take
  task automatic send(input logic [35:0] ad, input sad_pkg::sad_target_type tg,
                      input logic wr = 1'b0, input sad_pkg::sad_src_type src = CPU,
                      input logic sn = 1'b1, input logic mm = 1'b0, input logic io = 1'b0);
    int  n;
    logic rdy;
    @(negedge mclk);
    req_valid = 1'b1;
    req = '{addr: ad, write: wr, io: io, src: src, mgmt_mode: mm, snoop: sn};
    for (n = 0; n < 200; n++) begin
      #1;
      rdy = req_ready;
      @(posedge mclk);
      if (rdy === 1'b1) break;
      @(negedge mclk);
    end
    if (n == 200) begin
      err_count++;
      conclude();
    end
    exp_q.push_back('{tg, ad, io && tg == GX, ad[2], wr, io, src,
                      tg == HR && ad[35:28] == 8'h0e});
    req_valid <= 1'b0;
  endtask : send

  // waits until every result is back, so configuration may change
  task automatic drain();
    int n;
    for (n = 0; n < 500 && (exp_q.size() != 0 || out_valid !== 1'b0); n++) @(negedge mclk);
    if (n == 500) begin
      err_count++;
      conclude();
    end
  endtask : drain

  // result watcher: each accepted result against the oldest note
  always @(posedge mclk) begin
    if (rst === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected result", 36'h1, 36'h0);
      end else begin
        e = exp_q.pop_front();
        check("target", 36'(res_q.target), 36'(e.tgt));
        check("address", res_q.addr, e.addr);
        if (e.gchk) check("data port", 36'(res_q.gfx_io_data), 36'(e.gio));
        check("write", 36'(res_q.write), 36'(e.wr));
        check("io", 36'(res_q.io), 36'(e.io));
        check("source", 36'(res_q.src), 36'(e.src));
        check("cfg access", 36'(res_q.cfg_access), 36'(e.cacc));
      end
    end
  end

  // clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // watchdog
  initial begin
    repeat (50000) @(posedge mclk);
    err_count++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    err_count = 0;
    compares = 0;
    lfsr = 32'h4ff3e76d;
    cfg = '0;
    cfg.top_of_low_dram = 36'h0_2000_0000;
    cfg.win_base = {36'h0_d020_0010, 36'h0_d020_0000, 36'h0_d010_0000, 36'h0_c000_0000,
      36'hf_0000_0000, 36'h0_d000_0000, 36'h0_e000_0000, 36'h0_f002_0000, 36'h0_f001_0000,
      36'h0_f000_0000};
    cfg.win_en = '1;
    cfg.flat_size = 2'h2;
    cfg.io_base = {16'h1100, 16'h1000};
    cfg.io_en = '1;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    #1;
    check("idle valid", 36'(out_valid), 36'h0);
    check("idle ready", 36'(req_ready), 36'h1);
    check("reset target", 36'(res_q.target), 36'(HL));
    // low 640 KB, random offsets and directions
    for (i = 0; i < 8; i++) begin
      lfsr = next_rnd(lfsr);
      send(36'(lfsr[19:0] % 20'ha0000), DR, lfsr[31]);
    end
    send(36'h9ffff, DR, 1'b1, PCI);
    send(36'h0_1fff_ffff, DR);
    send(36'h0_2000_0000, HL);
    // stolen memory: 8 MB, then an oversize value clamped to 64 MB
    drain();
    cfg.stolen_mb = 7'h08;
    send(36'h0_1f80_0000, GX);
    send(36'h0_1f7f_ffff, DR);
    drain();
    cfg.stolen_mb = 7'h50;
    send(36'h0_1c00_0000, GX);
    send(36'h0_1bff_ffff, DR);
    drain();
    cfg.stolen_mb = 7'h00;
    for (i = 0; i < 13; i++) send(WA[i], WT[i]);
    for (p = 0; p < 2; p++) begin
      drain();
      cfg.flat_size = 2'(p);
      a = 36'h0_e000_0000 + (36'h400_0000 << p);
      send(a - 36'h1, HR);
      send(a, HL);
    end
    // window moved under dram loses to dram
    drain();
    cfg.win_base[sad_pkg::W_DLINK] = 36'h0_1000_0000;
    send(36'h0_1000_0000, DR);
    drain();
    cfg.win_base[sad_pkg::W_DLINK] = 36'h0_f002_0000;
    send(36'h1000, GX, 1'b1, CPU, 1'b1, 1'b0, 1'b1);
    send(36'h1004, GX, 1'b0, CPU, 1'b1, 1'b0, 1'b1);
    send(36'h1108, HL, 1'b0, CPU, 1'b1, 1'b0, 1'b1);
    send(36'h1104, MG, 1'b0, CPU, 1'b1, 1'b0, 1'b1);
    // legacy video steering: graphics, hub link, then pcie left selected
    for (p = 0; p < 3; p++) begin
      drain();
      cfg.gfx_vga_en = (p == 0);
      cfg.vga_en = (p == 2);
      send(36'ha0000, p == 0 ? GX : (p == 1 ? HL : PC));
    end
    for (i = 0; i < 6; i++) send(36'(sad_pkg::MONO_PORTS[i]), PC, 1'b0, CPU, 1'b1, 1'b0, 1'b1);
    send(36'h3b6, HL, 1'b0, CPU, 1'b1, 1'b0, 1'b1);
    drain();
    cfg.mono_adapter_present = 1'b1;
    send(36'hb0000, HL);
    send(36'hb7fff, HL);
    send(36'hb8000, PC);
    send(36'hafff0, PC);
    send(36'h3ba, HL, 1'b0, CPU, 1'b1, 1'b0, 1'b1);
    drain();
    cfg.mono_adapter_present = 1'b0;
    cfg.smram_en = 1'b1;
    send(36'ha0000, DR, 1'b0, CPU, 1'b1, 1'b1);
    send(36'ha0000, PC, 1'b1, CPU, 1'b1, 1'b0);
    send(36'ha8000, PC, 1'b1, HUB);
    send(36'ha8000, AB, 1'b0, HUB);
    send(36'ha8000, AB, 1'b1, PCI);
    drain();
    cfg.gfx_vga_en = 1'b1;
    send(36'ha8000, AB, 1'b1, HUB);
    // segment attributes, each pattern then its inverse, consumer stalling
    slow = 1'b1;
    lfsr = next_rnd(lfsr);
    for (p = 0; p < 2; p++) begin
      drain();
      cfg.seg_attr = p == 0 ? lfsr[23:0] : ~lfsr[23:0];
      for (i = 0; i < 12; i++) begin
        a = sad_pkg::SEG_BASE + 36'(i * 16'h4000) + 36'(lfsr[13:0]);
        send(a, cfg.seg_attr[2*i] ? DR : HL);
        send(a, cfg.seg_attr[2*i+1] ? DR : HL, 1'b1);
        send(a, cfg.seg_attr[2*i] ? DR : HL, 1'b0, HUB);
        send(a, DR, 1'b1, PCI, 1'b0);
      end
    end
    send(36'hf0000, HL);
    drain();
    conclude();
  end
endmodule : test_sad_decoder
